// ==== common/frp_defs.vh ====
// Constants for the flash rewrite and protect controller
`ifndef FRP_DEFS_VH
`define FRP_DEFS_VH

// Flash addresses fetched after reset
`define FRP_OPT_ADDR     16'hffff
`define FRP_RVEC_ADDR    16'hfffc
`define FRP_ID_ADDR0     16'hffdf
`define FRP_ID_STRIDE    16'h0004
`define FRP_ID_BYTES     7
`define FRP_FETCH_LAST   4'ha

// Option byte field positions
`define FRP_OPT_WDT      0
`define FRP_OPT_PEN      2
`define FRP_OPT_PROT     3
`define FRP_OPT_VMON     6
`define FRP_OPT_CSP      7
`define FRP_ERASED_BYTE  8'hff

// User ROM map: data flash, program ROM, option block
`define FRP_DF_LO        16'h3000
`define FRP_DF_HI        16'h3fff
`define FRP_PR_LO        16'h4000
`define FRP_OPT_BLK_LO   16'hc000

// Operation lengths in clock cycles
`define FRP_PROG_CYCLES  16'd40
`define FRP_ERASE_CYCLES 16'd400

`endif

// ==== logic/frp_id_check.v ====
// Serial-mode ID code store and comparator
`timescale 1ns/1ps
`default_nettype none
`include "frp_defs.vh"

module frp_id_check #(
   parameter N = `FRP_ID_BYTES
) (
   input  wire       clk,       // System clock
   input  wire       rst_b,     // Sync reset, low
   input  wire       ref_we,    // Stored byte load strobe
   input  wire [2:0] ref_idx,   // Stored byte index
   input  wire [7:0] ref_data,  // Stored byte value
   input  wire       clear,     // Forget a past match
   input  wire       id_valid,  // Received byte strobe
   input  wire [7:0] id_data,   // Received byte
   output reg        match_reg  // All bytes matched
);

   reg [7:0] ref_mem [0:N-1];
   reg [2:0] idx_reg;
   reg       miss_reg;
   integer   i;

   // ----------------------------------------
   // Stored bytes, loaded once after reset
   // ----------------------------------------
   always @(posedge clk) begin
      if (!rst_b) begin
         for (i = 0; i < N; i = i + 1)
            ref_mem[i] <= `FRP_ERASED_BYTE;
      end else if (ref_we) begin
         ref_mem[ref_idx] <= ref_data;
      end
   end

   // ----------------------------------------
   // Byte-by-byte compare of a received code
   // ----------------------------------------
   // A new code may be sent after a failed one; the verdict
   // only changes when the last byte of a code arrives, or on reset or clear.
   always @(posedge clk) begin
      if (!rst_b || clear) begin
         idx_reg   <= 3'h0;
         miss_reg  <= 1'b0;
         match_reg <= 1'b0;
      end else if (id_valid) begin
         if (idx_reg == N - 1) begin
            idx_reg   <= 3'h0;
            miss_reg  <= 1'b0;
            match_reg <= !miss_reg && (id_data == ref_mem[idx_reg]);
         end else begin
            idx_reg  <= idx_reg + 3'h1;
            miss_reg <= miss_reg || (id_data != ref_mem[idx_reg]);
         end
      end
   end

endmodule // frp_id_check
`default_nettype wire

// ==== logic/frp_op_seq.v ====
// Program / erase sequencer with erase-suspend
`timescale 1ns/1ps
`default_nettype none
`include "frp_defs.vh"

module frp_op_seq #(
   parameter [15:0] PROG_CYCLES  = `FRP_PROG_CYCLES,
   parameter [15:0] ERASE_CYCLES = `FRP_ERASE_CYCLES
) (
   input  wire clk,         // System clock
   input  wire rst_b,       // Sync reset, low
   input  wire start,       // Accepted command pulse
   input  wire start_erase, // Command is a block erase
   input  wire susp_cond,   // Suspend condition level
   input  wire fail_in,     // Array verify failure
   output wire busy,        // Operation running
   output wire suspended,   // Erase is suspended
   output reg  prog_done,   // Program finished pulse
   output reg  erase_done,  // Erase finished pulse
   output reg  prog_err,    // Last program failed
   output reg  erase_err    // Last erase failed
);

   localparam [2:0] S_IDLE  = 3'h0;
   localparam [2:0] S_PROG  = 3'h1;
   localparam [2:0] S_ERASE = 3'h2;
   localparam [2:0] S_SUSP  = 3'h3;
   localparam [2:0] S_SPROG = 3'h4;

   reg [2:0]  st_reg;
   reg [15:0] pcnt_reg;
   reg [15:0] ecnt_reg;

   assign busy      = (st_reg == S_PROG) || (st_reg == S_ERASE) ||
                      (st_reg == S_SPROG);
   assign suspended = (st_reg == S_SUSP) || (st_reg == S_SPROG);

   // ----------------------------------------
   // Operation state machine
   // ----------------------------------------
   // The erase count is kept across a suspend so the erase
   // resumes where it stopped rather than starting over.
   always @(posedge clk) begin
      if (!rst_b) begin
         st_reg     <= S_IDLE;
         pcnt_reg   <= 16'h0000;
         ecnt_reg   <= 16'h0000;
         prog_done  <= 1'b0;
         erase_done <= 1'b0;
         prog_err   <= 1'b0;
         erase_err  <= 1'b0;
      end else begin
         prog_done  <= 1'b0;
         erase_done <= 1'b0;
         case (st_reg)
            S_IDLE: begin
               if (start && start_erase) begin
                  st_reg    <= S_ERASE;
                  ecnt_reg  <= ERASE_CYCLES - 16'h0001;
                  erase_err <= 1'b0;
               end else if (start) begin
                  st_reg   <= S_PROG;
                  pcnt_reg <= PROG_CYCLES - 16'h0001;
                  prog_err <= 1'b0;
               end
            end
            S_PROG, S_SPROG: begin
               if (pcnt_reg == 16'h0000) begin
                  st_reg    <= (st_reg == S_SPROG) ? S_SUSP : S_IDLE;
                  prog_done <= 1'b1;
                  prog_err  <= fail_in;
               end else begin
                  pcnt_reg <= pcnt_reg - 16'h0001;
               end
            end
            S_ERASE: begin
               if (ecnt_reg == 16'h0000) begin
                  st_reg     <= S_IDLE;
                  erase_done <= 1'b1;
                  erase_err  <= fail_in;
               end else if (susp_cond) begin
                  st_reg <= S_SUSP;
               end else begin
                  ecnt_reg <= ecnt_reg - 16'h0001;
               end
            end
            S_SUSP: begin
               if (start && !start_erase) begin
                  st_reg   <= S_SPROG;
                  pcnt_reg <= PROG_CYCLES - 16'h0001;
                  prog_err <= 1'b0;
               end else if (!susp_cond) begin
                  st_reg <= S_ERASE;
               end
            end
            default: st_reg <= S_IDLE;
         endcase
      end
   end

endmodule // frp_op_seq
`default_nettype wire

// ==== logic/frp_ctrl.v ====
// Flash rewrite mode, protection and option byte controller
`timescale 1ns/1ps
`default_nettype none
`include "frp_defs.vh"

module frp_ctrl #(
   parameter [15:0] PROG_CYCLES  = `FRP_PROG_CYCLES,
   parameter [15:0] ERASE_CYCLES = `FRP_ERASE_CYCLES
) (
   input  wire        clk,                // 200 MHz clock
   input  wire        rst_b,              // Sync reset, low
   // Mode selection
   input  wire        serial_mode,        // Serial programmer mode
   input  wire        parallel_mode,      // Parallel programmer mode
   input  wire        cpu_rewrite_enable, // CPU rewrite enabled
   input  wire        submode_select,     // 1: sub-mode one
   // Suspend control
   input  wire        suspend_enable,     // Suspend allowed
   input  wire        suspend_request,    // Software suspend
   input  wire        interrupt_suspend_enable, // Irq suspend
   input  wire        irq_pending,        // Enabled irq pending
   // Flash array read port for start-up fetch
   output reg         fl_rd_req,          // Read request
   output reg  [15:0] fl_rd_addr,         // Read address
   input  wire        fl_rd_valid,        // Read data valid
   input  wire [7:0]  fl_rd_data,         // Read data
   // Command port shared by CPU and programmers
   input  wire        cmd_valid,          // Command request
   input  wire        cmd_erase,          // 1: block erase
   input  wire [15:0] cmd_addr,           // Target address
   input  wire [7:0]  cmd_data,           // Program data
   output reg         cmd_accept,         // Accepted pulse
   output reg         cmd_refuse,         // Refused pulse
   // Serial ID code
   input  wire        id_valid,           // ID byte strobe
   input  wire [7:0]  id_data,            // ID byte
   output wire        id_ok,              // Serial commands allowed
   // Flash array operation port
   output reg         array_start,        // Operation start pulse
   output reg         array_erase,        // Operation is erase
   output reg  [15:0] array_addr,         // Operation address
   output reg  [7:0]  array_data,         // Program data
   input  wire        array_fail,         // Verify failed
   output wire        array_suspend,      // Erase held
   // Status
   output wire        ready_busy_flag,    // 1 ready, 0 busy
   output wire        erase_error_flag,   // Erase failed
   output wire        program_error_flag, // Program failed
   output wire        erase_suspend_flag, // Erase suspended
   output wire        read_array_mode,    // Array readable
   output reg         cpu_hold,           // Hold CPU and DMA
   output reg         config_valid,       // Fetch finished
   output reg  [7:0]  option_select_byte, // Option byte copy
   output wire        parallel_protect,   // Protection active
   output wire        par_read_allow,     // Parallel reads allowed
   output wire        watchdog_start_sel, // Watchdog autostart
   output wire        voltage_monitor_start,    // Vmon reset on
   output wire        count_source_protect_init // Csp on
);

   localparam FS_FETCH = 1'b0;
   localparam FS_RUN   = 1'b1;

   reg        fs_reg;
   reg [3:0]  fidx_reg;
   reg        rvec_ff_reg;
   reg        op_df_reg;
   reg        hold_tgt_reg;
   reg [15:0] op_addr_reg;

   wire busy;
   wire suspended;
   wire prog_done;
   wire erase_done;
   wire match;
   wire prot_on;
   wire mode_ok;
   wire state_ok;
   wire accept;
   wire susp_cond;

   // ----------------------------------------
   // Address decode helpers
   // ----------------------------------------
   function is_data_flash;
      input [15:0] a;
      begin
         is_data_flash = (a >= `FRP_DF_LO) && (a <= `FRP_DF_HI);
      end
   endfunction

   // Boot ROM lies outside this window and is never a target
   function is_user_rom;
      input [15:0] a;
      begin
         is_user_rom = is_data_flash(a) || (a >= `FRP_PR_LO);
      end
   endfunction

   function [15:0] fetch_addr;
      input [3:0] k;
      begin
         if (k == 4'h0)
            fetch_addr = `FRP_OPT_ADDR;
         else if (k < 4'h4)
            fetch_addr = `FRP_RVEC_ADDR + {12'h000, k} - 16'h0001;
         else
            fetch_addr = `FRP_ID_ADDR0 +
                         {12'h000, k - 4'h4} * `FRP_ID_STRIDE;
      end
   endfunction

   // ----------------------------------------
   // Start-up fetch of option byte, vector, IDs
   // ----------------------------------------
   // Commands stay refused until the fetch ends so that
   // protection and ID checks never run on stale values.
   always @(posedge clk) begin
      if (!rst_b) begin
         fs_reg       <= FS_FETCH;
         fidx_reg     <= 4'h0;
         fl_rd_req    <= 1'b0;
         fl_rd_addr   <= 16'h0000;
         rvec_ff_reg  <= 1'b1;
         config_valid <= 1'b0;
      end else begin
         case (fs_reg)
            FS_FETCH: begin
               fl_rd_req  <= 1'b1;
               fl_rd_addr <= fetch_addr(fidx_reg);
               if (fl_rd_req && fl_rd_valid) begin
                  if (fidx_reg >= 4'h1 && fidx_reg <= 4'h3)
                     rvec_ff_reg <= rvec_ff_reg &&
                        (fl_rd_data == `FRP_ERASED_BYTE);
                  if (fidx_reg == `FRP_FETCH_LAST) begin
                     fs_reg       <= FS_RUN;
                     fl_rd_req    <= 1'b0;
                     config_valid <= 1'b1;
                  end else begin
                     fidx_reg   <= fidx_reg + 4'h1;
                     fl_rd_addr <= fetch_addr(fidx_reg + 4'h1);
                  end
               end
            end
            FS_RUN: fl_rd_req <= 1'b0;
            default: fs_reg <= FS_FETCH;
         endcase
      end
   end

   // ----------------------------------------
   // Option byte copy and its effects
   // ----------------------------------------
   // Program can only clear bits, so a program of the top
   // address ANDs in; an erase of its block restores all ones.
   always @(posedge clk) begin
      if (!rst_b) begin
         option_select_byte <= `FRP_ERASED_BYTE;
      end else if (fs_reg == FS_FETCH && fl_rd_req &&
                   fl_rd_valid && fidx_reg == 4'h0) begin
         option_select_byte <= fl_rd_data;
      end else if (erase_done && !erase_error_flag &&
                   op_addr_reg >= `FRP_OPT_BLK_LO) begin
         option_select_byte <= `FRP_ERASED_BYTE;
      end else if (prog_done && !program_error_flag &&
                   array_addr == `FRP_OPT_ADDR) begin
         option_select_byte <= option_select_byte & array_data;
      end
   end

   assign prot_on = option_select_byte[`FRP_OPT_PEN] &&
                    !option_select_byte[`FRP_OPT_PROT];
   assign parallel_protect = prot_on;
   assign par_read_allow   = parallel_mode && config_valid &&
                             !prot_on;
   assign watchdog_start_sel =
      !option_select_byte[`FRP_OPT_WDT];
   assign voltage_monitor_start =
      !option_select_byte[`FRP_OPT_VMON];
   assign count_source_protect_init =
      !option_select_byte[`FRP_OPT_CSP];

   // ----------------------------------------
   // Serial ID check
   // ----------------------------------------
   frp_id_check #(
      .N (`FRP_ID_BYTES)
   ) u_id (
      .clk       (clk),
      .rst_b     (rst_b),
      .ref_we    (fs_reg == FS_FETCH && fl_rd_req && fl_rd_valid &&
                  fidx_reg >= 4'h4),
      .ref_idx   (fidx_reg[2:0] - 3'h4),
      .ref_data  (fl_rd_data),
      .clear     (!serial_mode),
      .id_valid  (id_valid && serial_mode),
      .id_data   (id_data),
      .match_reg (match)
   );

   // Blank reset vector skips the check
   assign id_ok = serial_mode && config_valid &&
                  (rvec_ff_reg || match);

   // ----------------------------------------
   // Command acceptance
   // ----------------------------------------
   // Only one source is live at a time: the mode pins pick
   // serial, then parallel, else the CPU under its enable.
   assign mode_ok = serial_mode   ? id_ok :
                    parallel_mode ? !prot_on :
                    cpu_rewrite_enable;
   // While suspended only programs are taken
   assign state_ok = !busy && (!suspended || !cmd_erase);
   assign accept   = cmd_valid && config_valid && mode_ok &&
                     state_ok && is_user_rom(cmd_addr);

   // Suspend is a CPU-mode feature; sub-mode one takes the
   // software request only while data flash is rewritten.
   assign susp_cond = !serial_mode && !parallel_mode &&
      suspend_enable &&
      ((suspend_request && (!submode_select || op_df_reg)) ||
       (interrupt_suspend_enable && irq_pending));

   always @(posedge clk) begin
      if (!rst_b) begin
         cmd_accept  <= 1'b0;
         cmd_refuse  <= 1'b0;
         array_start <= 1'b0;
         array_erase <= 1'b0;
         array_addr  <= 16'h0000;
         array_data  <= 8'h00;
         op_addr_reg <= 16'h0000;
         op_df_reg   <= 1'b0;
      end else begin
         cmd_accept  <= accept;
         cmd_refuse  <= cmd_valid && !accept;
         array_start <= accept;
         if (accept) begin
            array_erase <= cmd_erase;
            array_addr  <= cmd_addr;
            array_data  <= cmd_data;
            // Keep the erase target while a program runs in
            // suspend, so the suspend rule and the option byte
            // clear still see it
            if (!suspended) begin
               op_df_reg   <= is_data_flash(cmd_addr);
               op_addr_reg <= cmd_addr;
            end
         end
      end
   end

   // ----------------------------------------
   // Operation sequencer
   // ----------------------------------------
   frp_op_seq #(
      .PROG_CYCLES  (PROG_CYCLES),
      .ERASE_CYCLES (ERASE_CYCLES)
   ) u_seq (
      .clk         (clk),
      .rst_b       (rst_b),
      .start       (accept),
      .start_erase (cmd_erase),
      .susp_cond   (susp_cond),
      .fail_in     (array_fail),
      .busy        (busy),
      .suspended   (suspended),
      .prog_done   (prog_done),
      .erase_done  (erase_done),
      .prog_err    (program_error_flag),
      .erase_err   (erase_error_flag)
   );

   assign ready_busy_flag    = !busy;
   assign erase_suspend_flag = suspended;
   assign array_suspend      = suspended && !busy;
   assign read_array_mode    = !busy;

   // ----------------------------------------
   // CPU and transfer controller hold
   // ----------------------------------------
   // Only sub-mode one on program ROM holds; data flash work
   // runs in the background and sub-mode zero never holds.
   // The target class is latched at accept and the hold follows
   // busy, so the CPU is freed on the edge that ready returns.
   always @(posedge clk) begin
      if (!rst_b) begin
         hold_tgt_reg <= 1'b0;
      end else if (accept) begin
         hold_tgt_reg <= submode_select && !serial_mode &&
                         !parallel_mode && !is_data_flash(cmd_addr);
      end
   end

   always @* begin
      cpu_hold = hold_tgt_reg && busy;
   end

endmodule // frp_ctrl
`default_nettype wire

// ==== testbench/frp_checker.sv ====
// Port assertions for the flash rewrite and protect controller
`timescale 1ns/1ps
`default_nettype none
module frp_checker (
   input wire logic        clk, rst_b, serial_mode, parallel_mode,
   input wire logic        cpu_rewrite_enable, submode_select,
   input wire logic        suspend_enable, suspend_request,
   input wire logic        interrupt_suspend_enable, irq_pending,
   input wire logic        fl_rd_req, cmd_valid, cmd_accept, cmd_refuse,
   input wire logic        id_ok, array_start, array_erase, cpu_hold,
   input wire logic        ready_busy_flag, erase_suspend_flag,
   input wire logic        parallel_protect, watchdog_start_sel,
   input wire logic        voltage_monitor_start, count_source_protect_init,
   input wire logic [7:0]  option_select_byte,
   input wire logic [15:0] fl_rd_addr, cmd_addr, array_addr
);
   // ----------------------------------------
   // Single clock domain, reset disables all
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   chk_fetch_top: assert property ($rose(rst_b) |=>
      fl_rd_req && fl_rd_addr == 16'hffff) else $error("fetch start");
   chk_accept_busy: assert property (cmd_accept |->
      array_start && !ready_busy_flag) else $error("accept not busy");
   chk_one_answer: assert property (
      !(cmd_accept && cmd_refuse)) else $error("accept and refuse");
   chk_protect_dec: assert property (parallel_protect ==
      (option_select_byte[2] && !option_select_byte[3]))
      else $error("protect decode");
   chk_par_refuse: assert property (parallel_mode && !serial_mode &&
      !cpu_rewrite_enable && parallel_protect && cmd_valid |=>
      !cmd_accept) else $error("protected rewrite taken");
   chk_serial_gate: assert property (serial_mode && !id_ok &&
      cmd_valid |=> cmd_refuse) else $error("serial without id");
   chk_wdt_sel: assert property (
      watchdog_start_sel == !option_select_byte[0]) else $error("wdt");
   chk_vmon_sel: assert property (
      voltage_monitor_start == !option_select_byte[6]) else $error("vmon");
   chk_csp_sel: assert property (
      count_source_protect_init == !option_select_byte[7])
      else $error("csp");
   chk_rom_only: assert property (cmd_valid &&
      cmd_addr < 16'h3000 |=> cmd_refuse) else $error("outside rom");
   chk_hold_scope: assert property (cpu_hold |->
      submode_select && array_addr >= 16'h4000) else $error("hold");
   // Erase ending on the same edge is allowed to win over suspend
   chk_susp_entry: assert property (!ready_busy_flag && array_erase &&
      suspend_enable && (interrupt_suspend_enable && irq_pending ||
      suspend_request && (!submode_select || array_addr < 16'h4000))
      |=> ready_busy_flag) else $error("no suspend");
endmodule // frp_checker

bind frp_ctrl frp_checker chk_i (.*);
`default_nettype wire

// ==== testbench/frp_flash_model.sv ====
// Flash array model serving the start-up fetch and verify results
`timescale 1ns/1ps
`default_nettype none
module frp_flash_model #(
   parameter int GAP = 1 // Idle cycles before each byte
) (
   input  wire logic        clk,         // System clock
   input  wire logic        fl_rd_req,   // Fetch request
   input  wire logic [15:0] fl_rd_addr,  // Fetch address
   output var  logic        fl_rd_valid, // Fetch data valid
   output var  logic [7:0]  fl_rd_data,  // Fetch data
   input  wire logic        fail_en,     // Force verify failure
   output wire logic        array_fail   // Verify result
);
   logic [7:0] mem [0:65535];
   int         wait_n;
   // Blank array reads all ones
   initial begin
      foreach (mem[i]) mem[i] = 8'hff;
      fl_rd_valid = 1'b0;
      fl_rd_data = 8'h00;
      wait_n = 0;
   end
   // Bus wanders while idle so stale data is never mistaken for valid
   always @(posedge clk) begin
      fl_rd_valid <= 1'b0;
      fl_rd_data <= ~fl_rd_data;
      if (fl_rd_req && !fl_rd_valid) begin
         if (wait_n < GAP) wait_n <= wait_n + 1;
         else begin
            wait_n <= 0;
            fl_rd_valid <= 1'b1;
            fl_rd_data <= mem[fl_rd_addr];
         end
      end
   end
   assign array_fail = fail_en;
endmodule // frp_flash_model
`default_nettype wire

// ==== testbench/test_flash_rewrite_protect_control.sv ====
// Bench for the flash rewrite and protect controller
`timescale 1ns/1ps
`default_nettype none
module test_flash_rewrite_protect_control;
   logic clk, rst_b, serial_mode, parallel_mode, cpu_rewrite_enable;
   logic submode_select, suspend_enable, suspend_request, fail_en;
   logic interrupt_suspend_enable, irq_pending, fl_rd_req, fl_rd_valid;
   logic [15:0] fl_rd_addr, cmd_addr, array_addr;
   logic [7:0] fl_rd_data, cmd_data, id_data, array_data;
   logic [7:0] option_select_byte;
   logic cmd_valid, cmd_erase, cmd_accept, cmd_refuse, id_valid, id_ok;
   logic array_start, array_erase, array_fail, array_suspend;
   logic ready_busy_flag, erase_error_flag, program_error_flag;
   logic erase_suspend_flag, read_array_mode, cpu_hold, config_valid;
   logic parallel_protect, par_read_allow, watchdog_start_sel;
   logic voltage_monitor_start, count_source_protect_init;
   int   bad_count, n_checks;

   // Short operation counts keep the run brief
   frp_ctrl #(.PROG_CYCLES(16'd4), .ERASE_CYCLES(16'd10)) uut (.*);
   frp_flash_model #(.GAP(1)) fm (.*);

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // ----------------------------------------
   // Checking and access tasks
   // ----------------------------------------
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic cyc(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // One-cycle request; the answer pulse follows the taking edge
   task automatic cmd(logic er, logic [15:0] a, logic ok);
      @(posedge clk);
      cmd_erase <= er;
      cmd_addr <= a;
      cmd_data <= a[7:0];
      cmd_valid <= 1'b1;
      @(posedge clk);
      cmd_valid <= 1'b0;
      #1 chk("accept", {15'd0, ok}, {15'd0, cmd_accept});
      chk("refuse", {15'd0, !ok}, {15'd0, cmd_refuse});
   endtask
   // Counts busy cycles; zero means do not compare the count
   task automatic wait_rdy(int exp);
      int n;
      n = 0;
      while (ready_busy_flag !== 1'b1 && n < 2000) begin
         n++;
         cyc(1);
      end
      if (n >= 2000) begin
         bad_count++;
         final_report;
      end
      if (exp > 0) chk("busy cycles", exp[15:0], n[15:0]);
   endtask
   task automatic send_id(logic [7:0] b);
      for (int k = 0; k < 7; k++) begin
         @(posedge clk);
         id_valid <= 1'b1;
         id_data <= b + k[7:0];
      end
      @(posedge clk);
      id_valid <= 1'b0;
      #1;
   endtask
   task automatic boot;
      int n;
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      #1 chk("reset option", 8'hff, option_select_byte);
      chk("reset ready", 1, ready_busy_flag);
      n = 0;
      while (config_valid !== 1'b1 && n < 200) begin
         n++;
         cyc(1);
      end
      if (n >= 200) begin
         bad_count++;
         final_report;
      end
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      {serial_mode, parallel_mode, cpu_rewrite_enable, submode_select} = 0;
      {suspend_enable, suspend_request, interrupt_suspend_enable} = 0;
      {irq_pending, cmd_valid, cmd_erase, id_valid, fail_en} = 0;
      {cmd_addr, cmd_data, id_data} = 0;
      rst_b = 1'b0;
      bad_count = 0;
      n_checks = 0;
      #1;
      fm.mem[16'hffff] = 8'h56;
      for (int k = 0; k < 7; k++) fm.mem[16'hffdf + 4 * k] = 8'h21 + k;
      boot;
      chk("option", 8'h56, option_select_byte);
      chk("wdt start", 1, watchdog_start_sel);
      chk("vmon start", 0, voltage_monitor_start);
      chk("csp init", 1, count_source_protect_init);
      chk("protect", 1, parallel_protect);
      @(posedge clk) parallel_mode <= 1'b1;
      cmd(0, 16'h3000, 0);
      chk("par read", 0, par_read_allow);
      $display("test option and protect done");
      @(posedge clk) parallel_mode <= 1'b0;
      cmd(0, 16'h3000, 0);
      @(posedge clk) cpu_rewrite_enable <= 1'b1;
      cmd(0, 16'h2fff, 0);
      cmd(0, 16'h3000, 1);
      wait_rdy(4);
      @(posedge clk) fail_en <= 1'b1;
      cmd(0, 16'h3001, 1);
      wait_rdy(4);
      chk("program error", 1, program_error_flag);
      @(posedge clk) fail_en <= 1'b0;
      cmd(1, 16'hc000, 1);
      wait_rdy(10);
      cyc(2);
      chk("erased option", 8'hff, option_select_byte);
      chk("unprotected", 0, parallel_protect);
      chk("erase error", 0, erase_error_flag);
      $display("test cpu rewrite done");
      cmd(1, 16'h3000, 1);
      @(posedge clk) {suspend_enable, suspend_request} <= 2'b11;
      cyc(2);
      chk("suspended", 1, erase_suspend_flag);
      chk("read array", 1, read_array_mode);
      chk("erase held", 1, array_suspend);
      cmd(1, 16'h3400, 0);
      cmd(0, 16'h3400, 1);
      wait_rdy(0);
      @(posedge clk) suspend_request <= 1'b0;
      cyc(2);
      chk("resumed", 0, ready_busy_flag);
      @(posedge clk) {interrupt_suspend_enable, irq_pending} <= 2'b11;
      cyc(2);
      chk("irq suspend", 1, erase_suspend_flag);
      @(posedge clk) irq_pending <= 1'b0;
      cyc(1);
      wait_rdy(0);
      $display("test erase suspend done");
      @(posedge clk) submode_select <= 1'b1;
      cmd(0, 16'h4000, 1);
      chk("hold rom", 1, cpu_hold);
      wait_rdy(4);
      chk("hold off", 0, cpu_hold);
      cmd(0, 16'h3002, 1);
      chk("hold data", 0, cpu_hold);
      wait_rdy(4);
      @(posedge clk) suspend_request <= 1'b1;
      cmd(1, 16'h4000, 1);
      cyc(2);
      chk("no rom suspend", 0, erase_suspend_flag);
      @(posedge clk) suspend_request <= 1'b0;
      wait_rdy(0);
      $display("test sub-mode one done");
      @(posedge clk) {cpu_rewrite_enable, serial_mode} <= 2'b01;
      cyc(1);
      chk("blank vector", 1, id_ok);
      cmd(0, 16'h3003, 1);
      wait_rdy(4);
      fm.mem[16'hfffc] = 8'h00;
      boot;
      chk("id locked", 0, id_ok);
      send_id(8'h30);
      cmd(0, 16'h3004, 0);
      send_id(8'h21);
      chk("id matched", 1, id_ok);
      cmd(0, 16'h3004, 1);
      chk("array data", 8'h04, array_data);
      wait_rdy(4);
      $display("test serial id done");
      final_report;
   end
endmodule // test_flash_rewrite_protect_control
`default_nettype wire
